// >>> rtl/clk_src_pkg.sv
// Constants and types shared by the clock source switch.
// Notes on behaviour
// RULE_01 - Every reset release runs the system clock from the internal oscillator.
// RULE_02 - Software sets modes and enables, waits for stability, then selects crystal.
// RULE_03 - Internal oscillator frequency after reset comes from a boot option byte.
// RULE_04 - Option bits select2=1, select1=0 run the internal oscillator at 1 MHz.
// RULE_05 - Detector-off option bit at 0 enables low-voltage detector after power-on.
// RULE_06 - Software clears high-speed bit only when system clock is 10 MHz or less.
// RULE_07 - RTC low-power bit at 1 keeps only the watch running in sub-halt.
// RULE_08 - Main oscillator select bit at 1 sets shared pins to crystal mode.
// RULE_09 - Software clears main amplifier high bit for crystals of 10 MHz or less.
// RULE_10 - Sub oscillator select bit at 1 puts shared pins in sub crystal mode.
// RULE_11 - Two sub amplifier mode bits choose sub crystal oscillation mode.
// RULE_12 - Clearing main oscillator stop bit starts the main crystal oscillator.
// RULE_13 - Mode control register accepts only its first write after reset.
// RULE_14 - Clearing sub oscillator stop bit starts the subsystem crystal oscillator.
// RULE_15 - No switch to main crystal before stabilisation counter reports done.
package clk_src_pkg;
  localparam logic [19:0] ADDR_BOOT_OPTION = 20'h000c1;
  localparam logic [19:0] ADDR_SPEED_MODE = 20'h00100;
  localparam logic [19:0] ADDR_OSC_MODE = 20'h00101;
  localparam logic [19:0] ADDR_RUN_CTRL = 20'h00102;
  localparam logic [19:0] ADDR_STAB_STATUS = 20'h00103;
  localparam logic [19:0] ADDR_CLK_SELECT = 20'h00104;
  // Boot option byte fields.
  localparam int OPT_FREQ_SEL2 = 3;
  localparam int OPT_FREQ_SEL1 = 1;
  localparam int OPT_LVD_OFF = 0;
  // Speed mode control fields.
  localparam int SPD_HIGH_SPEED = 0;
  localparam int SPD_FLASH_LP = 1;
  localparam int SPD_RTC_LP = 7;
  // Oscillator mode control fields.
  localparam int OMC_AMP_HIGH = 0;
  localparam int OMC_SUB_AMP0 = 1;
  localparam int OMC_SUB_AMP1 = 2;
  localparam int OMC_SUB_SEL = 4;
  localparam int OMC_MAIN_SEL = 6;
  localparam int OMC_EXT_CLK = 7;
  // Run control fields.
  localparam int RUN_MAIN_STOP = 7;
  localparam int RUN_SUB_STOP = 6;
  localparam int RUN_INT_STOP = 0;
  // Clock select fields.
  localparam int CKS_MAIN = 0;
  localparam int CKS_SUB = 1;
  localparam logic [7:0] SPEED_MODE_RESET = 8'h00;
  localparam logic [7:0] OSC_MODE_RESET = 8'h00;
  localparam logic [7:0] RUN_CTRL_RESET = 8'hc0;
  localparam logic [7:0] CLK_SELECT_RESET = 8'h00;
  localparam logic [1:0] FREQ_1MHZ = 2'h2;
  localparam int STAB_TIME_US = 100;
  localparam int CLK_MHZ = 100;
  localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
  localparam int STAB_W = 16;
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_SUB = 2'h3
  } clk_src_t;
endpackage

// >>> rtl/osc_if.sv
// Interface carrying one oscillator's control and stability status.
`timescale 1ns/1ps
`default_nettype none
interface osc_if;
  logic run;
  logic stable;
  modport ctrl (output run, input stable);
  modport osc (input run, output stable);
endinterface
`default_nettype wire

// >>> rtl/osc_stab_counter.sv
// Stabilisation counter for one crystal oscillator.
`timescale 1ns/1ps
`default_nettype none
module osc_stab_counter
  import clk_src_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES = STAB_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  osc_if.osc link
);
  typedef struct packed {
    logic [STAB_W-1:0] count;
    logic stable;
  } state_t;
  localparam logic [STAB_W-1:0] LAST = STAB_W'(WAIT_CYCLES - 1);
  state_t st;
  state_t next_st;
  always_comb begin
    next_st = st;
    // A stopped oscillator loses stability at once and restarts the wait.
    if (!link.run) begin
      next_st.count = '0;
      next_st.stable = 1'b0;
    end else if (!st.stable) begin
      if (st.count == LAST) begin
        next_st.stable = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else if (en_i) begin
      st <= next_st;
    end
  end
  assign link.stable = st.stable;
endmodule
`default_nettype wire

// >>> rtl/main_clock_source_switch.sv
// System clock source control with oscillator enables and switch-over.
`timescale 1ns/1ps
`default_nettype none
module main_clock_source_switch
  import clk_src_pkg::*;
#(
  parameter int unsigned MAIN_WAIT = STAB_CYCLES,
  parameter int unsigned SUB_WAIT = STAB_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic por_flag_i,
  input wire logic [7:0] boot_option_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic sub_halt_i,
  output logic [7:0] rdata_o,
  output logic [1:0] clk_source_o,
  output logic [1:0] int_osc_freq_o,
  output logic int_osc_1mhz_o,
  output logic low_voltage_detector_o,
  output logic main_crystal_oscillator_o,
  output logic main_osc_pins_o,
  output logic main_amp_high_freq_o,
  output logic external_main_clock_select_o,
  output logic subsystem_crystal_oscillator_o,
  output logic sub_osc_pins_o,
  output logic [1:0] sub_amp_mode_o,
  output logic high_speed_operation_o,
  output logic flash_low_power_o,
  output logic watch_only_o
);
  typedef struct packed {
    logic [7:0] speed_mode_control;
    logic [7:0] oscillator_mode_control;
    logic mode_written;
    logic [7:0] oscillator_run_control;
    logic [7:0] system_clock_select;
    clk_src_t src;
    logic [7:0] boot_option;
    logic boot_taken;
    logic lvd_on;
    logic [7:0] rdata;
    logic por_meta;
    logic por_sync;
  } state_t;

  state_t st;
  state_t next_st;
  osc_if main_link();
  osc_if sub_link();

  // Decodes a bus address into a strobe match for a given register.
  function automatic logic hit(input logic [19:0] a, input logic [19:0] r);
    hit = (a == r);
  endfunction

  assign main_link.run = ~st.oscillator_run_control[RUN_MAIN_STOP]; // RULE_12
  assign sub_link.run = ~st.oscillator_run_control[RUN_SUB_STOP]; // RULE_14

  osc_stab_counter #(.WAIT_CYCLES(MAIN_WAIT)) u_main_stab (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .en_i(clk_en_i),
    .link(main_link.osc)
  );

  osc_stab_counter #(.WAIT_CYCLES(SUB_WAIT)) u_sub_stab (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .en_i(clk_en_i),
    .link(sub_link.osc)
  );

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    // The power-on flag is a foreign level, so it passes two flops first.
    next_st.por_meta = por_flag_i;
    next_st.por_sync = st.por_meta;
    // Strap capture happens after release; the byte is held stable by flash.
    if (!st.boot_taken) begin
      next_st.boot_taken = 1'b1;
      next_st.boot_option = boot_option_i; // RULE_03
    end
    // The power-on flag is only trustworthy once it has crossed both flops,
    // so the detector comes on three cycles after release.
    if (st.boot_taken && st.por_sync && !st.boot_option[OPT_LVD_OFF]) begin
      next_st.lvd_on = 1'b1; // RULE_05
    end
    if (wr_i) begin
      if (hit(addr_i, ADDR_SPEED_MODE)) begin
        next_st.speed_mode_control = wdata_i;
      end
      // Later writes are dropped so a crashed program cannot retune pins.
      if (hit(addr_i, ADDR_OSC_MODE) && !st.mode_written) begin // RULE_13
        next_st.oscillator_mode_control = wdata_i;
        next_st.mode_written = 1'b1;
      end
      if (hit(addr_i, ADDR_RUN_CTRL)) begin
        next_st.oscillator_run_control = wdata_i;
      end
      if (hit(addr_i, ADDR_CLK_SELECT)) begin
        next_st.system_clock_select = wdata_i;
      end
    end
    if (rd_i) begin
      unique case (1'b1)
        hit(addr_i, ADDR_BOOT_OPTION): next_st.rdata = st.boot_option;
        hit(addr_i, ADDR_SPEED_MODE): next_st.rdata = st.speed_mode_control;
        hit(addr_i, ADDR_OSC_MODE): begin
          next_st.rdata = st.oscillator_mode_control;
        end
        hit(addr_i, ADDR_RUN_CTRL): begin
          next_st.rdata = st.oscillator_run_control;
        end
        hit(addr_i, ADDR_STAB_STATUS): begin
          next_st.rdata = {6'h00, sub_link.stable, main_link.stable};
        end
        hit(addr_i, ADDR_CLK_SELECT): begin
          next_st.rdata = {st.system_clock_select[7:2], st.src};
        end
        default: next_st.rdata = 8'h00;
      endcase
    end
    // A source is only granted while its oscillator is running and settled.
    unique case (st.src)
      SRC_INTERNAL: begin
        if (st.system_clock_select[CKS_MAIN] && main_link.stable
            && st.oscillator_mode_control[OMC_MAIN_SEL]) begin // RULE_15
          next_st.src = SRC_MAIN;
        end else if (st.system_clock_select[CKS_SUB] && sub_link.stable
            && st.oscillator_mode_control[OMC_SUB_SEL]) begin
          next_st.src = SRC_SUB;
        end
      end
      SRC_MAIN: begin
        if (!st.system_clock_select[CKS_MAIN] || !main_link.stable) begin
          next_st.src = SRC_INTERNAL;
        end
      end
      SRC_SUB: begin
        if (!st.system_clock_select[CKS_SUB] || !sub_link.stable) begin
          next_st.src = SRC_INTERNAL;
        end
      end
      default: next_st.src = SRC_INTERNAL;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.speed_mode_control <= SPEED_MODE_RESET;
      st.oscillator_mode_control <= OSC_MODE_RESET;
      st.oscillator_run_control <= RUN_CTRL_RESET;
      st.system_clock_select <= CLK_SELECT_RESET;
      st.src <= SRC_INTERNAL; // RULE_01
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // Outputs sampled again so each leaves the block from a flop.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
      clk_source_o <= SRC_INTERNAL;
      int_osc_freq_o <= 2'h0;
      int_osc_1mhz_o <= 1'b0;
      low_voltage_detector_o <= 1'b0;
      main_crystal_oscillator_o <= 1'b0;
      main_osc_pins_o <= 1'b0;
      main_amp_high_freq_o <= 1'b0;
      external_main_clock_select_o <= 1'b0;
      subsystem_crystal_oscillator_o <= 1'b0;
      sub_osc_pins_o <= 1'b0;
      sub_amp_mode_o <= 2'h0;
      high_speed_operation_o <= 1'b0;
      flash_low_power_o <= 1'b0;
      watch_only_o <= 1'b0;
    end else if (clk_en_i) begin
      rdata_o <= next_st.rdata;
      clk_source_o <= next_st.src;
      int_osc_freq_o <= {next_st.boot_option[OPT_FREQ_SEL2],
                         next_st.boot_option[OPT_FREQ_SEL1]};
      int_osc_1mhz_o <= {next_st.boot_option[OPT_FREQ_SEL2],
                         next_st.boot_option[OPT_FREQ_SEL1]}
                        == FREQ_1MHZ; // RULE_04
      low_voltage_detector_o <= next_st.lvd_on;
      main_crystal_oscillator_o <=
        ~next_st.oscillator_run_control[RUN_MAIN_STOP]; // RULE_12
      main_osc_pins_o <= next_st.oscillator_mode_control[OMC_MAIN_SEL]; // RULE_08
      main_amp_high_freq_o <= next_st.oscillator_mode_control[OMC_AMP_HIGH];
      external_main_clock_select_o <=
        next_st.oscillator_mode_control[OMC_EXT_CLK];
      subsystem_crystal_oscillator_o <=
        ~next_st.oscillator_run_control[RUN_SUB_STOP]; // RULE_14
      sub_osc_pins_o <= next_st.oscillator_mode_control[OMC_SUB_SEL]; // RULE_10
      sub_amp_mode_o <= {next_st.oscillator_mode_control[OMC_SUB_AMP1],
                         next_st.oscillator_mode_control[OMC_SUB_AMP0]}; // RULE_11
      high_speed_operation_o <= next_st.speed_mode_control[SPD_HIGH_SPEED];
      flash_low_power_o <= next_st.speed_mode_control[SPD_FLASH_LP];
      watch_only_o <= sub_halt_i
                      && next_st.speed_mode_control[SPD_RTC_LP]; // RULE_07
    end
  end
endmodule
`default_nettype wire

// >>> sim/main_clock_source_switch_asserts.sv
// Port-level assertions for the clock source switch.
`timescale 1ns/1ps
`default_nettype none
module main_clock_source_switch_asserts
  import clk_src_pkg::*;
#(
  parameter int unsigned MAIN_WAIT = STAB_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] boot_option_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic sub_halt_i,
  input wire logic [1:0] clk_source_o,
  input wire logic [1:0] int_osc_freq_o,
  input wire logic int_osc_1mhz_o,
  input wire logic low_voltage_detector_o,
  input wire logic main_crystal_oscillator_o,
  input wire logic subsystem_crystal_oscillator_o,
  input wire logic main_osc_pins_o,
  input wire logic sub_osc_pins_o,
  input wire logic [1:0] sub_amp_mode_o,
  input wire logic watch_only_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic mode_done;
  logic run_w;
  logic mode_w;
  int unsigned on_cnt;
  assign run_w = wr_i && clk_en_i && addr_i == ADDR_RUN_CTRL;
  assign mode_w = wr_i && clk_en_i && addr_i == ADDR_OSC_MODE;
  // Run time of the main oscillator; it freezes with the design.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_done <= 1'b0;
      on_cnt <= 0;
    end else if (clk_en_i) begin
      mode_done <= mode_done | mode_w;
      if (!main_crystal_oscillator_o)
        on_cnt <= 0;
      else if (on_cnt < MAIN_WAIT)
        on_cnt <= on_cnt + 1;
    end
  end
  a_reset_src: assert property ($rose(nrst_i) |->
    clk_source_o == SRC_INTERNAL) else $error("source not internal");
  a_freq_opt: assert property ($past(nrst_i) |->
    int_osc_freq_o == {boot_option_i[OPT_FREQ_SEL2],
    boot_option_i[OPT_FREQ_SEL1]}) else $error("bad osc frequency");
  a_one_mhz: assert property (
    int_osc_1mhz_o == (int_osc_freq_o == FREQ_1MHZ)) else $error("bad 1mhz");
  a_lvd_opt: assert property (low_voltage_detector_o |->
    !boot_option_i[OPT_LVD_OFF]) else $error("detector on with off bit");
  a_watch_only: assert property ($past(clk_en_i) && watch_only_o |->
    $past(sub_halt_i)) else $error("watch only outside halt");
  a_main_start: assert property (run_w |=>
    main_crystal_oscillator_o != $past(wdata_i[RUN_MAIN_STOP]))
    else $error("main oscillator run wrong");
  a_sub_start: assert property (run_w |=>
    subsystem_crystal_oscillator_o != $past(wdata_i[RUN_SUB_STOP]))
    else $error("sub oscillator run wrong");
  a_mode_first: assert property (mode_w && !mode_done |=>
    main_osc_pins_o == $past(wdata_i[OMC_MAIN_SEL]) &&
    sub_osc_pins_o == $past(wdata_i[OMC_SUB_SEL]) &&
    sub_amp_mode_o == {$past(wdata_i[OMC_SUB_AMP1]),
    $past(wdata_i[OMC_SUB_AMP0])}) else $error("mode write not taken");
  a_mode_once: assert property (mode_w && mode_done |=>
    $stable(main_osc_pins_o) && $stable(sub_amp_mode_o))
    else $error("second mode write taken");
  a_main_wait: assert property (clk_source_o == SRC_MAIN |->
    on_cnt >= MAIN_WAIT - 1) else $error("switched before stable");
endmodule
bind main_clock_source_switch main_clock_source_switch_asserts
  #(.MAIN_WAIT(MAIN_WAIT)) chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
  .boot_option_i(boot_option_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .sub_halt_i(sub_halt_i), .clk_source_o(clk_source_o),
  .int_osc_freq_o(int_osc_freq_o), .int_osc_1mhz_o(int_osc_1mhz_o),
  .low_voltage_detector_o(low_voltage_detector_o),
  .main_crystal_oscillator_o(main_crystal_oscillator_o),
  .subsystem_crystal_oscillator_o(subsystem_crystal_oscillator_o),
  .main_osc_pins_o(main_osc_pins_o), .sub_osc_pins_o(sub_osc_pins_o),
  .sub_amp_mode_o(sub_amp_mode_o), .watch_only_o(watch_only_o)
);
`default_nettype wire

// >>> sim/main_clock_source_switch_test.sv
// Self-checking bench for the clock source switch.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module main_clock_source_switch_test import clk_src_pkg::*;;
  localparam int WAIT = 8;
  logic sys_clk_i = 0, nrst_i = 0, clk_en_i = 1, por_flag_i = 1;
  logic wr_i = 0, rd_i = 0, sub_halt_i = 0;
  logic [7:0] boot_option_i = 8'hf8, wdata_i = 8'h00, rdata_o;
  logic [19:0] addr_i = 20'h00000;
  logic [1:0] clk_source_o, int_osc_freq_o, sub_amp_mode_o;
  logic int_osc_1mhz_o, low_voltage_detector_o, main_crystal_oscillator_o;
  logic main_osc_pins_o, main_amp_high_freq_o, external_main_clock_select_o;
  logic subsystem_crystal_oscillator_o, sub_osc_pins_o, watch_only_o;
  logic high_speed_operation_o, flash_low_power_o;
  int n_fail = 0, tests_run = 0, cycles = 0;
  main_clock_source_switch #(.MAIN_WAIT(WAIT), .SUB_WAIT(WAIT)) uut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
    .por_flag_i(por_flag_i), .boot_option_i(boot_option_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .sub_halt_i(sub_halt_i), .rdata_o(rdata_o),
    .clk_source_o(clk_source_o), .int_osc_freq_o(int_osc_freq_o),
    .int_osc_1mhz_o(int_osc_1mhz_o),
    .low_voltage_detector_o(low_voltage_detector_o),
    .main_crystal_oscillator_o(main_crystal_oscillator_o),
    .main_osc_pins_o(main_osc_pins_o),
    .main_amp_high_freq_o(main_amp_high_freq_o),
    .external_main_clock_select_o(external_main_clock_select_o),
    .subsystem_crystal_oscillator_o(subsystem_crystal_oscillator_o),
    .sub_osc_pins_o(sub_osc_pins_o), .sub_amp_mode_o(sub_amp_mode_o),
    .high_speed_operation_o(high_speed_operation_o),
    .flash_low_power_o(flash_low_power_o), .watch_only_o(watch_only_o)
  );
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hung run is cut short well after the whole sequence should be over.
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic reset_dut(input logic [7:0] opt);
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    boot_option_i <= opt;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    tick(2);
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask
  initial begin
    reset_dut(8'hf8);
    `CHK(clk_source_o, SRC_INTERNAL)
    `CHK(int_osc_freq_o, FREQ_1MHZ)
    `CHK(int_osc_1mhz_o, 1'b1)
    rd(ADDR_SPEED_MODE, SPEED_MODE_RESET);
    rd(ADDR_OSC_MODE, OSC_MODE_RESET);
    rd(ADDR_RUN_CTRL, RUN_CTRL_RESET);
    rd(ADDR_CLK_SELECT, CLK_SELECT_RESET);
    rd(20'h00105, 8'h00);
    `CHK(low_voltage_detector_o, 1'b1)
    wr(ADDR_SPEED_MODE, 8'h83);
    @(posedge sys_clk_i) sub_halt_i <= 1'b1;
    tick(2);
    `CHK(high_speed_operation_o, 1'b1)
    `CHK(flash_low_power_o, 1'b1)
    `CHK(watch_only_o, 1'b1)
    // A write while the clock enable is low must leave no trace.
    @(posedge sys_clk_i) clk_en_i <= 1'b0;
    wr(ADDR_SPEED_MODE, 8'h00);
    @(posedge sys_clk_i) clk_en_i <= 1'b1;
    rd(ADDR_SPEED_MODE, 8'h83);
    wr(ADDR_SPEED_MODE, 8'h00);
    tick(1);
    `CHK(high_speed_operation_o, 1'b0)
    `CHK(watch_only_o, 1'b0)
    wr(ADDR_OSC_MODE, 8'h56);
    tick(1);
    `CHK(main_osc_pins_o, 1'b1)
    `CHK(sub_osc_pins_o, 1'b1)
    `CHK(sub_amp_mode_o, 2'h3)
    `CHK(main_amp_high_freq_o, 1'b0)
    wr(ADDR_OSC_MODE, 8'h81);
    tick(1);
    `CHK(main_osc_pins_o, 1'b1)
    `CHK(external_main_clock_select_o, 1'b0)
    rd(ADDR_OSC_MODE, 8'h56);
    wr(ADDR_RUN_CTRL, 8'h40);
    wr(ADDR_CLK_SELECT, 8'h01);
    tick(1);
    `CHK(main_crystal_oscillator_o, 1'b1)
    `CHK(subsystem_crystal_oscillator_o, 1'b0)
    `CHK(clk_source_o, SRC_INTERNAL)
    tick(WAIT);
    rd(ADDR_STAB_STATUS, 8'h01);
    wr(ADDR_CLK_SELECT, 8'h01);
    tick(2);
    `CHK(clk_source_o, SRC_MAIN)
    wr(ADDR_RUN_CTRL, 8'h00);
    tick(1);
    `CHK(subsystem_crystal_oscillator_o, 1'b1)
    reset_dut(8'hfb);
    `CHK(clk_source_o, SRC_INTERNAL)
    `CHK(int_osc_freq_o, 2'h3)
    `CHK(int_osc_1mhz_o, 1'b0)
    `CHK(main_crystal_oscillator_o, 1'b0)
    tick(2);
    `CHK(low_voltage_detector_o, 1'b0)
    // Without a power-on flag the detector stays off whatever the option says.
    @(posedge sys_clk_i) por_flag_i <= 1'b0;
    reset_dut(8'hf8);
    tick(2);
    `CHK(low_voltage_detector_o, 1'b0)
    `CHK(int_osc_1mhz_o, 1'b1)
    results();
  end
endmodule
`default_nettype wire
